// file: design/tao_alarm_bank.sv
// Purpose: register bank and pin logic of the two thermal alarm outputs
// Assumes: over-limit inputs are synchronous to sys_clk
// Notes:   one wait state on every bus access; lock cleared only by reset_n
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ps
`include "tao_cfg.svh"

// Summary of operation
// - boost bit 0 clear: first alarm asserted forces fans to full speed.
// - boost bit 1 clear: second alarm asserted forces fans to full speed.
// - bits 4:2 pick first timer window 0.25 to 8 s; codes above 100 give 8 s.
// - bits 7:5 pick second timer window, same encoding as the first.
// - first config bit 0 enables first timer; timer idle when zero.
// - first config bit 1 lets local over-limit pull first alarm low.
// - first config bits 2..4 let remote 1..3 pull first alarm low.
// - second config bit 0 enables second timer; idle when zero.
// - second config bit 1 lets local over-limit pull second alarm low.
// - second config bits 2..4 let remote 1..3 pull second alarm low.
// - config bits 7:5 reserved, read zero, writes ignored.
// - boost/window register resets to 0x40, also on soft reset; locked.
// - second config at index 0x0f, resets to zero, soft reset, locked.
module tao_alarm_bank
  import tao_pkg::*;
#(
  parameter int unsigned QTR_CYCLES = `TAO_QTR_CYCLES
)
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // avalon-mm slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // interrupt
  output logic             irq,
  // over-limit flags: bit 0 local, bits 1..3 remote 1..3
  input  wire logic [3:0]  first_alarm_over,
  input  wire logic [3:0]  second_alarm_over,
  // open-drain alarm pins
  output logic             first_thermal_alarm_pin_o,
  output logic             first_thermal_alarm_pin_oe_n,
  output logic             second_thermal_alarm_pin_o,
  output logic             second_thermal_alarm_pin_oe_n,
  // fan override
  output logic             fan_full_speed
);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  localparam logic [`TAO_DIV_W-1:0] QTR_LAST = `TAO_DIV_W'(QTR_CYCLES - 1);

  tao_state_s              st;
  tao_state_s              next_st;
  logic [`TAO_IDX_W-1:0]   idx;
  logic                    aligned;
  logic                    acc_wr;
  logic                    hit_boost;
  logic                    hit_cfg1;
  logic                    hit_cfg2;
  logic                    hit_stat;
  logic                    hit_mask;
  logic                    hit_ctrl;
  logic                    soft_rst;
  logic                    src1_hit;
  logic                    src2_hit;
  logic [1:0]              next_pin;
  logic [31:0]             rd_mux;
  logic [`TAO_EV_W-1:0]    events;
  logic [1:0]              tmr_en;
  logic [`TAO_WIN_W-1:0]   win_code [2];
  logic [`TAO_CNT_W-1:0]   tmr_ticks [2];
  logic [1:0]              tmr_done;

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  // a write takes effect only in the cycle waitrequest is low; read data is sampled the cycle before
  assign idx       = avs_address[7:2];
  assign aligned   = (avs_address[1:0] == 2'h0);
  assign acc_wr    = avs_write & st.ack & avs_byteenable[0];
  assign hit_boost = aligned && (idx == `TAO_IDX_BOOST);
  assign hit_cfg1  = aligned && (idx == `TAO_IDX_CFG1);
  assign hit_cfg2  = aligned && (idx == `TAO_IDX_CFG2);
  assign hit_stat  = aligned && (idx == `TAO_IDX_STAT);
  assign hit_mask  = aligned && (idx == `TAO_IDX_MASK);
  assign hit_ctrl  = aligned && (idx == `TAO_IDX_CTRL);
  assign soft_rst  = acc_wr && hit_ctrl && avs_writedata[`TAO_CTRL_SWRST_BIT];

  // ----------------------------------------------------------------------
  // alarm sources
  // ----------------------------------------------------------------------
  // each pin is the OR of its enabled channels
  assign src1_hit = |(first_alarm_over & st.cfg1[`TAO_SRC_MSB:`TAO_SRC_LSB]);
  assign src2_hit = |(second_alarm_over & st.cfg2[`TAO_SRC_MSB:`TAO_SRC_LSB]);
  assign next_pin = {src2_hit, src1_hit};

  // events: pin rising edges and finished timer windows
  always_comb
  begin
    events                = '0;
    events[`TAO_EV_RISE1] = next_pin[0] & ~st.pin[0];
    events[`TAO_EV_RISE2] = next_pin[1] & ~st.pin[1];
    events[`TAO_EV_WIN1]  = tmr_done[0];
    events[`TAO_EV_WIN2]  = tmr_done[1];
  end

  // ----------------------------------------------------------------------
  // assertion timers
  // ----------------------------------------------------------------------
  assign tmr_en[0]   = st.cfg1[`TAO_TMR_EN_BIT];
  assign tmr_en[1]   = st.cfg2[`TAO_TMR_EN_BIT];
  assign win_code[0] = st.boost[`TAO_WIN1_LSB +: `TAO_WIN_W];
  assign win_code[1] = st.boost[`TAO_WIN2_LSB +: `TAO_WIN_W];

  for (genvar g = 0; g < 2; g++)
  begin : gen_timer
    tao_assert_timer u_timer (
      .sys_clk        (sys_clk),
      .reset_n        (reset_n),
      .enable         (tmr_en[g]),
      .tick           (st.tick),
      .alarm          (st.pin[g]),
      .win_code       (win_code[g]),
      .asserted_ticks (tmr_ticks[g]),
      .window_done    (tmr_done[g])
    );
  end

  // ----------------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------------
  // reserved config bits and unmapped addresses read as zero
  always_comb
  begin
    rd_mux = '0;
    if (aligned)
    begin
      unique case (idx)
        `TAO_IDX_BOOST: rd_mux[7:0]           = st.boost;
        `TAO_IDX_CFG1:  rd_mux[`TAO_CFG_W-1:0] = st.cfg1;
        `TAO_IDX_CFG2:  rd_mux[`TAO_CFG_W-1:0] = st.cfg2;
        `TAO_IDX_STAT:  rd_mux[`TAO_EV_W-1:0]  = st.status;
        `TAO_IDX_MASK:  rd_mux[`TAO_EV_W-1:0]  = st.mask;
        `TAO_IDX_CTRL:  rd_mux[`TAO_CTRL_LOCK_BIT] = st.lock;
        `TAO_IDX_STATE: rd_mux[14:0] = {tmr_ticks[1], tmr_ticks[0], st.fan_full, st.pin};
        default:        rd_mux = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_st     = st;
    // one wait state: ack rises in the cycle after the request appears
    next_st.ack = (avs_read | avs_write) & ~st.ack;
    if (avs_read && !st.ack)
      next_st.rdata = rd_mux;

    // quarter-second tick divider
    next_st.tick = 1'b0;
    if (st.qdiv == QTR_LAST)
    begin
      next_st.qdiv = '0;
      next_st.tick = 1'b1;
    end
    else
      next_st.qdiv = st.qdiv + `TAO_DIV_W'(1);

    // soft reset reloads the locked registers even when locked
    if (soft_rst)
    begin
      next_st.boost = `TAO_BOOST_RST;
      next_st.cfg1  = `TAO_CFG_RST;
      next_st.cfg2  = `TAO_CFG_RST;
    end
    else if (acc_wr && !st.lock)
    begin
      if (hit_boost)
        next_st.boost = avs_writedata[7:0];
      if (hit_cfg1)
        next_st.cfg1 = avs_writedata[`TAO_CFG_W-1:0];
      if (hit_cfg2)
        next_st.cfg2 = avs_writedata[`TAO_CFG_W-1:0];
    end

    // lock is set-only; no write can undo it before reset_n
    if (acc_wr && hit_ctrl && avs_writedata[`TAO_CTRL_LOCK_BIT])
      next_st.lock = 1'b1;
    if (acc_wr && hit_mask)
      next_st.mask = avs_writedata[`TAO_EV_W-1:0];

    // write one to clear; a new event in the same cycle wins
    next_st.status = st.status | events;
    if (acc_wr && hit_stat)
      next_st.status = (st.status & ~avs_writedata[`TAO_EV_W-1:0]) | events;

    // pins and fan override are registered together
    next_st.pin      = next_pin;
    next_st.fan_full = (next_pin[0] & ~next_st.boost[`TAO_BOOST1_BIT])
                     | (next_pin[1] & ~next_st.boost[`TAO_BOOST2_BIT]);
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st       <= '0;
      st.boost <= `TAO_BOOST_RST;
      st.cfg1  <= `TAO_CFG_RST;
      st.cfg2  <= `TAO_CFG_RST;
    end
    else
      st <= next_st;
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign avs_readdata                  = st.rdata;
  assign avs_waitrequest               = (avs_read | avs_write) & ~st.ack;
  assign irq                           = |(st.status & st.mask);
  assign first_thermal_alarm_pin_o     = 1'b0;
  assign first_thermal_alarm_pin_oe_n  = ~st.pin[0];
  assign second_thermal_alarm_pin_o    = 1'b0;
  assign second_thermal_alarm_pin_oe_n = ~st.pin[1];
  assign fan_full_speed                = st.fan_full;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  first_boost_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (!first_thermal_alarm_pin_oe_n && !st.boost[`TAO_BOOST1_BIT]) |-> fan_full_speed)
    else $error("first alarm asserted without fan boost");

  second_boost_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (fan_full_speed && !(!first_thermal_alarm_pin_oe_n && !st.boost[`TAO_BOOST1_BIT]))
    |-> (!second_thermal_alarm_pin_oe_n && !st.boost[`TAO_BOOST2_BIT]))
    else $error("fan boost without a cause");

  first_pin_set_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    src1_hit |=> !first_thermal_alarm_pin_oe_n)
    else $error("first alarm not driven low");

  second_pin_set_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    src2_hit |=> !second_thermal_alarm_pin_oe_n)
    else $error("second alarm not driven low");

  pin_release_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (!src1_hit && !src2_hit) |=> (first_thermal_alarm_pin_oe_n && second_thermal_alarm_pin_oe_n))
    else $error("alarm pin not released");

  reserved_read_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (avs_read && !avs_waitrequest && (hit_cfg1 || hit_cfg2))
    |-> avs_readdata[`TAO_CFG_RSV_MSB:`TAO_CFG_RSV_LSB] == 3'h0)
    else $error("reserved config bits read non-zero");

  boost_lock_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (acc_wr && hit_boost && st.lock) |=> $stable(st.boost))
    else $error("locked boost register changed");

  soft_reset_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    soft_rst |=> (st.boost == `TAO_BOOST_RST && st.cfg1 == `TAO_CFG_RST))
    else $error("soft reset did not reload defaults");

  cfg2_lock_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (acc_wr && hit_cfg2 && st.lock && !soft_rst) |=> $stable(st.cfg2))
    else $error("locked second config changed");

  timer_gate_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (!tmr_en[1] && $past(!tmr_en[1])) |-> (tmr_ticks[1] == '0 && !tmr_done[1]))
    else $error("second timer ran while disabled");

  event_wins_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    events[`TAO_EV_RISE1] |=> st.status[`TAO_EV_RISE1] ##0 !first_thermal_alarm_pin_oe_n)
    else $error("first alarm rise lost");

endmodule : tao_alarm_bank

// file: design/tao_cfg.svh
// Purpose: constants for the thermal alarm output block
// Assumes: included by bare name; guarded against double inclusion
// Notes:   indices are word indices, the byte address is four times the index
`ifndef TAO_CFG_SVH
`define TAO_CFG_SVH

// ----------------------------------------------------------------------
// register indices
// ----------------------------------------------------------------------
`define TAO_IDX_W         6
`define TAO_IDX_BOOST     6'h0c
`define TAO_IDX_CFG1      6'h0e
`define TAO_IDX_CFG2      6'h0f
`define TAO_IDX_STAT      6'h20
`define TAO_IDX_MASK      6'h21
`define TAO_IDX_CTRL      6'h22
`define TAO_IDX_STATE     6'h23

// ----------------------------------------------------------------------
// reset values and fields
// ----------------------------------------------------------------------
`define TAO_BOOST_RST     8'h40
`define TAO_CFG_RST       5'h00
`define TAO_BOOST1_BIT    0
`define TAO_BOOST2_BIT    1
`define TAO_WIN1_LSB      2
`define TAO_WIN2_LSB      5
`define TAO_WIN_W         3
`define TAO_TMR_EN_BIT    0
`define TAO_SRC_MSB       4
`define TAO_SRC_LSB       1
`define TAO_CFG_W         5
`define TAO_CFG_RSV_MSB   7
`define TAO_CFG_RSV_LSB   5
`define TAO_CTRL_LOCK_BIT 0
`define TAO_CTRL_SWRST_BIT 1
`define TAO_EV_W          4
`define TAO_EV_RISE1      0
`define TAO_EV_RISE2      1
`define TAO_EV_WIN1       2
`define TAO_EV_WIN2       3

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define TAO_CLK_HZ        10000000
`define TAO_QTR_MS        250
`define TAO_QTR_CYCLES    (`TAO_CLK_HZ / 1000 * `TAO_QTR_MS)
`define TAO_DIV_W         22
`define TAO_CNT_W         6
`define TAO_WIN_CODE_MAX  3'h5

`endif

// file: design/tao_pkg.sv
// Purpose: types shared by the thermal alarm output block
// Assumes: tao_cfg.svh holds every width used here except the fixed 32-bit read data, 8-bit boost and 2-bit pin fields
// Notes:   state of each module is one packed struct
`include "tao_cfg.svh"

package tao_pkg;

  // timer state: window position, accumulated and last result
  typedef struct packed {
    logic [`TAO_CNT_W-1:0] pos;
    logic [`TAO_CNT_W-1:0] acc;
    logic [`TAO_CNT_W-1:0] result;
    logic                  done;
  } tao_timer_s;

  // register bank state
  typedef struct packed {
    logic                  ack;
    logic [31:0]           rdata;
    logic [7:0]            boost;
    logic [`TAO_CFG_W-1:0] cfg1;
    logic [`TAO_CFG_W-1:0] cfg2;
    logic                  lock;
    logic [`TAO_EV_W-1:0]  status;
    logic [`TAO_EV_W-1:0]  mask;
    logic [1:0]            pin;
    logic                  fan_full;
    logic [`TAO_DIV_W-1:0] qdiv;
    logic                  tick;
  } tao_state_s;

endpackage : tao_pkg

// file: design/tao_assert_timer.sv
// Purpose: measures how many quarter-second ticks an alarm is asserted per window
// Assumes: tick is a one-cycle pulse every quarter second
// Notes:   window shortened mid-run to its current position or less closes at the next tick
`timescale 1ns/1ps
`include "tao_cfg.svh"

module tao_assert_timer
  import tao_pkg::*;
(
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  reset_n,
  // control
  input  wire logic                  enable,
  input  wire logic                  tick,
  input  wire logic                  alarm,
  input  wire logic [`TAO_WIN_W-1:0] win_code,
  // results
  output logic      [`TAO_CNT_W-1:0] asserted_ticks,
  output logic                       window_done
);

  tao_timer_s            st;
  tao_timer_s            next_st;
  logic [`TAO_CNT_W-1:0] len_last;
  logic [`TAO_WIN_W-1:0] code_sat;

  // codes above the maximum all give the longest window
  always_comb
  begin
    code_sat = (win_code > `TAO_WIN_CODE_MAX) ? `TAO_WIN_CODE_MAX : win_code;
    len_last = (`TAO_CNT_W'(1) << code_sat) - `TAO_CNT_W'(1);
  end

  // window counting; disabled timer holds everything cleared
  always_comb
  begin
    next_st      = st;
    next_st.done = 1'b0;
    if (!enable)
    begin
      next_st.pos    = '0;
      next_st.acc    = '0;
      next_st.result = '0;
    end
    else if (tick)
    begin
      if (st.pos >= len_last)
      begin
        next_st.result = st.acc + `TAO_CNT_W'(alarm);
        next_st.acc    = '0;
        next_st.pos    = '0;
        next_st.done   = 1'b1;
      end
      else
      begin
        next_st.pos = st.pos + `TAO_CNT_W'(1);
        next_st.acc = st.acc + `TAO_CNT_W'(alarm);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign asserted_ticks = st.result;
  assign window_done    = st.done;

  // window never overruns its selected length
  win_length_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    st.pos <= len_last || $past(tick) == 1'b0 || !enable)
    else $error("timer window position beyond selected length");

  // a disabled timer stays cleared
  timer_off_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !enable |=> (st.pos == '0 && st.acc == '0 && !st.done))
    else $error("disabled timer still counting");

endmodule : tao_assert_timer

// file: bench/tao_board_model.sv
// Purpose: board side of the two open-drain thermal alarm lines
// Assumes: each line has a pull-up on the board
// Notes:   a released line reads high, never the last driven value
`timescale 1ns/1ps

module tao_board_model
(
  // pin drivers of the block
  input  wire logic first_pin_o,
  input  wire logic first_pin_oe_n,
  input  wire logic second_pin_o,
  input  wire logic second_pin_oe_n,
  // resolved board lines
  output logic      first_pin_line,
  output logic      second_pin_line
);
  // pull-up wins whenever the block lets go of the line
  assign first_pin_line  = first_pin_oe_n ? 1'b1 : first_pin_o;
  assign second_pin_line = second_pin_oe_n ? 1'b1 : second_pin_o;
endmodule : tao_board_model

// file: bench/testbench.sv
// Purpose: self-checking bench of the thermal alarm register bank
// Assumes: quarter-second tick shortened to 4 cycles
// Notes:   lock test runs last, since only reset_n clears the lock
`timescale 1ns/1ps
`include "tao_cfg.svh"

module testbench;
  import tao_pkg::*;
  localparam int unsigned QTR     = 4;
  localparam logic [7:0]  A_BOOST = {`TAO_IDX_BOOST, 2'b00};
  localparam logic [7:0]  A_CFG1  = {`TAO_IDX_CFG1, 2'b00};
  localparam logic [7:0]  A_CFG2  = {`TAO_IDX_CFG2, 2'b00};
  localparam logic [7:0]  A_STAT  = {`TAO_IDX_STAT, 2'b00};
  localparam logic [7:0]  A_MASK  = {`TAO_IDX_MASK, 2'b00};
  localparam logic [7:0]  A_CTRL  = {`TAO_IDX_CTRL, 2'b00};
  localparam logic [7:0]  A_STATE = {`TAO_IDX_STATE, 2'b00};
  logic        sys_clk, reset_n, avs_read, avs_write, avs_waitrequest, irq;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd_val;
  logic [3:0]  avs_byteenable, first_alarm_over, second_alarm_over;
  logic        p1_o, p1_oe_n, p2_o, p2_oe_n, fan_full_speed, line1, line2;
  int          errors, n_compared;

  tao_alarm_bank #(.QTR_CYCLES(QTR)) u_tao_alarm_bank
  (
    .sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq),
    .first_alarm_over(first_alarm_over), .second_alarm_over(second_alarm_over),
    .first_thermal_alarm_pin_o(p1_o), .first_thermal_alarm_pin_oe_n(p1_oe_n),
    .second_thermal_alarm_pin_o(p2_o), .second_thermal_alarm_pin_oe_n(p2_oe_n),
    .fan_full_speed(fan_full_speed)
  );

  tao_board_model u_tao_board_model
  (
    .first_pin_o(p1_o), .first_pin_oe_n(p1_oe_n), .second_pin_o(p2_o),
    .second_pin_oe_n(p2_oe_n), .first_pin_line(line1), .second_pin_line(line2)
  );

  // clock
  always #50 sys_clk = ~sys_clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // one avalon access; waitrequest and read data are taken at the rising edge
  task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    int guard;
    @(posedge sys_clk);
    avs_address   <= addr;
    avs_read      <= ~wr;
    avs_write     <= wr;
    avs_writedata <= data;
    guard = 0;
    do
    begin
      @(posedge sys_clk);
      guard++;
    end
    while (avs_waitrequest !== 1'b0 && guard < 20);
    check(guard < 20, 1'b1, "bus answer");
    rd_val = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    bus(1'b1, addr, data);
  endtask : wr

  task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp, input string what);
    bus(1'b0, addr, 32'h0);
    check(rd_val, exp, what);
  endtask : rd_chk

  task automatic set_over(input int a, input logic [3:0] v);
    @(posedge sys_clk);
    if (a == 0) first_alarm_over <= v;
    else second_alarm_over <= v;
  endtask : set_over

  // pins and fan are registered: two edges, then look mid-cycle
  task automatic settle;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : settle

  task automatic t_reset_values;
    rd_chk(A_BOOST, 32'h40, "boost reset");
    rd_chk(A_CFG1, 32'h0, "cfg1 reset");
    rd_chk(A_CFG2, 32'h0, "cfg2 reset");
    rd_chk(8'h14, 32'h0, "unmapped read");
    rd_chk(8'h31, 32'h0, "misaligned read");
    wr(A_CFG1, 32'hff);
    rd_chk(A_CFG1, 32'h1f, "cfg1 reserved");
    wr(A_CFG2, 32'hff);
    rd_chk(A_CFG2, 32'h1f, "cfg2 reserved");
    wr(A_CFG1, 32'h0);
    // a write without its low byte lane enabled must be ignored
    avs_byteenable <= 4'he;
    wr(A_CFG1, 32'h1f);
    avs_byteenable <= 4'hf;
    rd_chk(A_CFG1, 32'h0, "byteenable gate");
    wr(A_CFG2, 32'h0);
  endtask : t_reset_values

  // each source alone: only its enable may pull the pin, and rise raises irq
  task automatic t_sources;
    wr(A_MASK, 32'h3);
    for (int a = 0; a < 2; a++)
      for (int k = 0; k < 4; k++)
      begin
        wr(a ? A_CFG2 : A_CFG1, 32'h1 << (k + 1));
        wr(A_STAT, 32'hf);
        set_over(a, ~(4'h1 << k));
        settle;
        check(a ? line2 : line1, 1'b1, "disabled sources");
        check(irq, 1'b0, "irq quiet");
        set_over(a, 4'h1 << k);
        settle;
        check(a ? line2 : line1, 1'b0, "enabled source");
        check(fan_full_speed, 1'b1, "fan boost");
        check(irq, 1'b1, "irq on rise");
        wr(A_STAT, 32'h1 << a);
        settle;
        check(irq, 1'b0, "irq cleared");
        set_over(a, 4'h0);
        settle;
        check(a ? line2 : line1, 1'b1, "pin released");
        check(fan_full_speed, 1'b0, "fan released");
      end
    // each boost bit governs only its own alarm
    for (int a = 0; a < 2; a++)
      for (int b = 0; b < 2; b++)
      begin
        wr(A_BOOST, 32'h40 | (b ? (32'h1 << a) : (32'h1 << (1 - a))));
        wr(a ? A_CFG2 : A_CFG1, 32'h02);
        set_over(a, 4'h1);
        settle;
        check(fan_full_speed, (b == 0), "boost select");
        set_over(a, 4'h0);
        wr(a ? A_CFG2 : A_CFG1, 32'h0);
      end
    wr(A_MASK, 32'h0);
  endtask : t_sources

  task automatic wait_done(input int a);
    int guard;
    wr(A_STAT, 32'hf);
    guard = 0;
    do
    begin
      bus(1'b0, A_STAT, 32'h0);
      guard++;
    end
    while (rd_val[2+a] !== 1'b1 && guard < 200);
    check(guard < 200, 1'b1, "window end");
  endtask : wait_done

  // alarm held through a whole window: every tick of it counts
  task automatic t_timer(input int a, input int code);
    int unsigned wlen;
    wlen = 1 << ((code > 5) ? 5 : code);
    wr(A_BOOST, 32'h03 | (code << (a ? 5 : 2)));
    wr(a ? A_CFG2 : A_CFG1, 32'h03);
    set_over(a, 4'h1);
    wait_done(a);
    wait_done(a);
    rd_chk(A_STATE, (32'h1 << a) | (wlen << (a ? 9 : 3)), "window ticks");
    wr(a ? A_CFG2 : A_CFG1, 32'h02);
    wr(A_STAT, 32'hf);
    repeat (80) @(posedge sys_clk);
    rd_chk(A_STAT, 32'h0, "timer off status");
    rd_chk(A_STATE, 32'h1 << a, "timer off result");
    set_over(a, 4'h0);
    wr(a ? A_CFG2 : A_CFG1, 32'h0);
  endtask : t_timer

  task automatic t_lock;
    wr(A_BOOST, 32'h1f);
    wr(A_CFG1, 32'h05);
    wr(A_CFG2, 32'h09);
    wr(A_CTRL, 32'h1);
    wr(A_BOOST, 32'hff);
    rd_chk(A_BOOST, 32'h1f, "locked boost");
    wr(A_CFG2, 32'h1f);
    rd_chk(A_CFG2, 32'h09, "locked cfg2");
    wr(A_CTRL, 32'h2);
    rd_chk(A_BOOST, 32'h40, "soft reset boost");
    rd_chk(A_CFG1, 32'h0, "soft reset cfg1");
    rd_chk(A_CFG2, 32'h0, "soft reset cfg2");
    rd_chk(A_CTRL, 32'h1, "lock kept");
  endtask : t_lock

  task automatic final_report;
    if (errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  // main sequence
  initial
  begin
    sys_clk = 1'b0;
    reset_n = 1'b0;
    avs_address = 8'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    first_alarm_over = 4'h0;
    second_alarm_over = 4'h0;
    errors = 0;
    n_compared = 0;
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_reset_values;
    t_sources;
    for (int a = 0; a < 2; a++)
      for (int c = 0; c < 8; c++)
        t_timer(a, c);
    t_lock;
    final_report;
  end

  // watchdog: the full run needs well under a millisecond
  initial
  begin
    #5000000;
    errors++;
    final_report;
  end
endmodule : testbench
